/* hdl/jl_pkg.sv */
/*
  Constants, register map and types for the load jam protection stage.
  Assumes a 20 MHz pclk and currents scaled in 0.01 x nominal.
*/
package jl_pkg;
  // Clock and program cycle timing
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned CYCLE_MS      = 5;
  localparam int unsigned TICK_CLKS_DEF = CYCLE_MS * 1000000 / CLK_NS;
  // History taps for the record currents
  localparam int unsigned PRE_MS        = 20;
  localparam int unsigned PREF_MS       = 200;
  localparam int unsigned PRE_TAPS      = PRE_MS / CYCLE_MS;
  localparam int unsigned PREF_TAPS     = PREF_MS / CYCLE_MS;
  localparam int unsigned HIST_DEPTH    = PREF_TAPS + 1;
  localparam int unsigned REC_DEPTH     = 12;
  // Widths
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned TW            = 20;
  localparam int unsigned RW            = 24;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_PICKUP  = 8'h04;
  localparam logic [7:0] OFF_OPDLY   = 8'h08;
  localparam logic [7:0] OFF_RLDLY   = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_EXPECT  = 8'h14;
  localparam logic [7:0] OFF_REMAIN  = 8'h18;
  localparam logic [7:0] OFF_RATIO   = 8'h1C;
  localparam logic [7:0] OFF_CNT_ST  = 8'h20;
  localparam logic [7:0] OFF_CNT_TR  = 8'h24;
  localparam logic [7:0] OFF_CNT_BL  = 8'h28;
  localparam logic [7:0] OFF_STAMP   = 8'h2C;
  localparam logic [7:0] OFF_REC_SEL = 8'h30;
  localparam logic [7:0] OFF_REC_TS  = 8'h34;
  localparam logic [7:0] OFF_REC_INF = 8'h38;
  localparam logic [7:0] OFF_REC_CUR = 8'h3C;
  localparam logic [7:0] OFF_REC_PF  = 8'h40;
  // Control fields and reset values
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_ON     = 1;
  localparam int unsigned CTRL_OFF    = 2;
  localparam int unsigned CTRL_GRP    = 3;
  localparam logic [5:0]  CTRL_RST    = 6'h07;
  localparam logic [15:0] PICKUP_RST  = 16'h0258;
  localparam logic [19:0] OPDLY_RST   = 20'h0_00C8;
  localparam logic [19:0] RLDLY_RST   = 20'h0_0000;
  // Ratio scale, one hundredth steps
  localparam logic [23:0] RATIO_SCALE = 24'h00_0064;
  // Event flag positions
  localparam int unsigned EV_ST_ON  = 0;
  localparam int unsigned EV_ST_OFF = 1;
  localparam int unsigned EV_TR_ON  = 2;
  localparam int unsigned EV_TR_OFF = 3;
  localparam int unsigned EV_BL_ON  = 4;
  localparam int unsigned EV_BL_OFF = 5;
  localparam logic [5:0]  EV_ON_MASK = 6'h15;
  // Stage condition, Gray along normal-start-trip
  typedef enum logic [1:0] {
    JL_NORMAL  = 2'b00,
    JL_START   = 2'b01,
    JL_TRIP    = 2'b11,
    JL_BLOCKED = 2'b10
  } jl_state_t;
endpackage : jl_pkg

/* hdl/jl_ratio_div.sv */
/*
  Serial restoring divider for the current to pick-up ratio.
  Assumes start pulses are spaced by more than NW clocks.
*/
`timescale 1ns/100ps
module jl_ratio_div #(
  parameter int unsigned NW = 24,  // Dividend width
  parameter int unsigned DW = 16   // Divisor width
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Request
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  // Result
  output logic               done,
  output logic [NW-1:0]      quo
);
  localparam int unsigned CW = $clog2(NW + 1);

  logic [DW-1:0] den_q;  // Divisor held for the whole run
  logic [DW:0]   rem;    // Partial remainder
  logic [CW-1:0] left;   // Bits still to produce
  logic          busy;   // Division running

  wire [DW:0] rem_sh = {rem[DW-1:0], quo[NW-1]};
  wire        ge     = rem_sh >= {1'b0, den_q};

  // One quotient bit per clock; a zero divisor yields all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      den_q <= '0;
      rem   <= '0;
      quo   <= '0;
      left  <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (start) begin
      den_q <= den;
      rem   <= '0;
      quo   <= num;
      left  <= CW'(NW);
      busy  <= 1'b1;
      done  <= 1'b0;
    end else if (busy) begin
      rem   <= ge ? rem_sh - {1'b0, den_q} : rem_sh;
      quo   <= {quo[NW-2:0], ge};
      left  <= left - 1'b1;
      busy  <= left != CW'(1);
      done  <= left == CW'(1);
    end else begin
      done  <= 1'b0;
    end
  end
endmodule : jl_ratio_div

/* hdl/jl_load_jam.sv */
/*
  Load jam protection stage: pick-up, definite time trip and release,
  blocking, events, counters and a ring of fault records, on APB.
  Assumes phase currents from logic on pclk and a blocking pin from
  outside the clock domain.
*/
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module jl_load_jam #(
  parameter int unsigned TICK_CLKS = jl_pkg::TICK_CLKS_DEF, // Clocks per program cycle
  parameter int unsigned CUR_W     = 16                      // Phase current width
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [jl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Phase currents and blocking
  input  wire logic [CUR_W-1:0]          i_l1,
  input  wire logic [CUR_W-1:0]          i_l2,
  input  wire logic [CUR_W-1:0]          i_l3,
  input  wire logic                      block_in,
  // Stage outputs
  output logic                           start,
  output logic                           trip,
  output logic                           blocked,
  // Event stream to the main event buffer
  output logic                           evt_valid,
  output logic [5:0]                     evt_flags,
  output logic [31:0]                    evt_stamp
);
  import jl_pkg::*;

  if (TICK_CLKS < 64 || CUR_W < 8 || CUR_W > 16) begin : g_chk
    $error("jl_load_jam: unsupported TICK_CLKS or CUR_W");
  end

  localparam int unsigned HW = $clog2(HIST_DEPTH);
  localparam int unsigned QW = $clog2(REC_DEPTH);

  // Index n entries behind the slot before pointer p, in a ring of d
  function automatic int back(input int p, input int n, input int d);
    int t;
    t = p - 1 - n;
    if (t < 0) t = t + d;
    if (t < 0) t = t + d;
    return t;
  endfunction : back

  // Larger of two currents
  function automatic logic [15:0] max2(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction : max2

  // Program cycle timebase
  logic [31:0]  tick_cnt;    // Clocks within the program cycle
  logic         tick;        // Program cycle boundary
  logic         upd;         // Cycle after the boundary
  logic [31:0]  stamp;       // Time stamp in program cycles
  // Blocking synchroniser and sample
  logic         blk_s1;      // First stage, read by blk_s2 only
  logic         blk_s2;      // Synchronised blocking level
  logic         blk_smp;     // Level taken at the cycle start
  // Settings
  logic [5:0]   ctrl;        // Enable, edge selects, setting group
  logic [15:0]  pickup;      // Pick-up, 0.01 x nominal
  logic [TW-1:0] opdly;      // Operate delay in program cycles
  logic [TW-1:0] rldly;      // Release delay in program cycles
  logic [QW-1:0] rsel;       // Record selector, 0 is newest
  // Stage state
  jl_state_t    state;
  jl_state_t    next_state;
  logic [TW-1:0] elapsed;
  logic [TW-1:0] next_elapsed;
  logic [TW-1:0] rel_cnt;
  logic [TW-1:0] next_rel_cnt;
  logic         releasing;
  logic         next_releasing;
  // Event edge tracking
  logic         p_start;
  logic         p_trip;
  logic         p_blk;
  logic [31:0]  cnt_st;      // Start occurrences
  logic [31:0]  cnt_tr;      // Trip occurrences
  logic [31:0]  cnt_bl;      // Blocked occurrences
  // Measured data history and records
  logic [15:0]  hist [HIST_DEPTH];
  logic [HW-1:0] hp;         // Next history slot
  logic [2:0]   ph_q;        // Phases over pick-up at the cycle
  logic [15:0]  pf_hold;     // Prefault current kept from start
  logic [31:0]  rec_ts  [REC_DEPTH];
  logic [31:0]  rec_inf [REC_DEPTH];
  logic [31:0]  rec_cur [REC_DEPTH];
  logic [15:0]  rec_pf  [REC_DEPTH];
  logic [QW-1:0] rec_wp;     // Next record slot
  // Ratio result
  logic         div_done;
  logic [RW-1:0] div_quo;
  logic [RW-1:0] ratio;
  // APB read path
  logic [31:0]  rd_mux;
  logic         err_q;

  // Highest phase current and pickup decision
  wire [15:0] c1      = 16'(i_l1);
  wire [15:0] c2      = 16'(i_l2);
  wire [15:0] c3      = 16'(i_l3);
  wire [15:0] cur_max = max2(max2(c1, c2), c3);
  wire [2:0]  ph_over = {c3 > pickup, c2 > pickup, c1 > pickup};
  wire        pick    = ctrl[CTRL_EN] && (cur_max > pickup);
  wire [TW-1:0] remain = (opdly > elapsed) ? opdly - elapsed : '0;

  // Program cycle counter and time stamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
      upd      <= 1'b0;
      stamp    <= '0;
    end else begin
      tick     <= tick_cnt == 32'(TICK_CLKS - 1);
      tick_cnt <= (tick_cnt == 32'(TICK_CLKS - 1)) ? '0 : tick_cnt + 1'b1;
      upd      <= tick;
      stamp    <= tick ? stamp + 1'b1 : stamp;
    end
  end

  // Two-stage synchroniser; the second stage feeds the evaluation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end else begin
      blk_s1 <= block_in;
      blk_s2 <= blk_s1;
    end
  end

  // Definite time operate and release, evaluated once per cycle
  always_comb begin
    next_state     = state;
    next_elapsed   = elapsed;
    next_rel_cnt   = rel_cnt;
    next_releasing = releasing;
    case (state)
      JL_NORMAL: begin
        if (pick && blk_s2) begin
          next_state = JL_BLOCKED;
        end else if (pick) begin
          next_state     = JL_START;
          next_releasing = 1'b0;
        end else if (releasing) begin
          // Timing resumes if pick-up returns before the release ends
          if (rel_cnt + 1'b1 >= rldly) begin
            next_elapsed   = '0;
            next_releasing = 1'b0;
          end else begin
            next_rel_cnt = rel_cnt + 1'b1;
          end
        end
      end
      JL_START: begin
        if (blk_s2 || !pick) begin
          next_state     = JL_NORMAL;
          next_releasing = 1'b1;
          next_rel_cnt   = '0;
        end else if (elapsed + 1'b1 >= opdly) begin
          next_state   = JL_TRIP;
          next_elapsed = opdly;
        end else begin
          next_elapsed = elapsed + 1'b1;
        end
      end
      JL_TRIP: begin
        if (blk_s2 || !pick) begin
          next_state     = JL_NORMAL;
          next_elapsed   = '0;
          next_releasing = 1'b0;
        end
      end
      JL_BLOCKED: begin
        if (!(pick && blk_s2)) begin
          next_state = JL_NORMAL;
        end
      end
      default: begin
        next_state = JL_NORMAL;
      end
    endcase
  end

  // State registers move only at the program cycle boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= JL_NORMAL;
      elapsed   <= '0;
      rel_cnt   <= '0;
      releasing <= 1'b0;
      blk_smp   <= 1'b0;
      start     <= 1'b0;
      trip      <= 1'b0;
      blocked   <= 1'b0;
      ph_q      <= '0;
    end else if (tick) begin
      // The block source must lead the delay by one program cycle
      blk_smp   <= blk_s2;
      state     <= next_state;
      elapsed   <= next_elapsed;
      rel_cnt   <= next_rel_cnt;
      releasing <= next_releasing;
      start     <= next_state == JL_START || next_state == JL_TRIP;
      trip      <= next_state == JL_TRIP;
      blocked   <= next_state == JL_BLOCKED;
      ph_q      <= ph_over;
    end
  end

  // Edge detection and selection of the stored edges
  wire [5:0] ev_raw = {p_blk & ~blocked, blocked & ~p_blk,
                       p_trip & ~trip, trip & ~p_trip,
                       p_start & ~start, start & ~p_start};
  wire [5:0] ev_sel = {3{ctrl[CTRL_OFF], ctrl[CTRL_ON]}};
  wire [5:0] ev_out = ev_raw & ev_sel;
  wire       rec_trig = upd && |(ev_raw & EV_ON_MASK);

  // Event stream and cumulative counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_start   <= 1'b0;
      p_trip    <= 1'b0;
      p_blk     <= 1'b0;
      evt_valid <= 1'b0;
      evt_flags <= '0;
      evt_stamp <= '0;
      cnt_st    <= '0;
      cnt_tr    <= '0;
      cnt_bl    <= '0;
    end else begin
      evt_valid <= upd && |ev_out;
      evt_flags <= upd ? ev_out : '0;
      if (upd) begin
        p_start   <= start;
        p_trip    <= trip;
        p_blk     <= blocked;
        evt_stamp <= stamp;
        cnt_st    <= cnt_st + 32'(ev_raw[EV_ST_ON]);
        cnt_tr    <= cnt_tr + 32'(ev_raw[EV_TR_ON]);
        cnt_bl    <= cnt_bl + 32'(ev_raw[EV_BL_ON]);
      end
    end
  end

  // History of the highest current, one slot per program cycle
  wire [HW-1:0] hp_nxt = (hp == HW'(HIST_DEPTH - 1)) ? '0 : hp + 1'b1;
  wire [15:0]   h_now  = hist[HW'(back(int'(hp), 0, HIST_DEPTH))];
  wire [15:0]   h_pre  = hist[HW'(back(int'(hp), PRE_TAPS, HIST_DEPTH))];
  wire [15:0]   h_pf   = hist[HW'(back(int'(hp), PREF_TAPS, HIST_DEPTH))];
  wire [15:0]   pf_val = ev_raw[EV_TR_ON] ? pf_hold : h_pf;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp      <= '0;
      pf_hold <= '0;
      for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= '0;
    end else begin
      if (tick) begin
        hist[hp] <= cur_max;
        hp       <= hp_nxt;
      end
      if (upd && ev_raw[EV_ST_ON]) pf_hold <= h_pf;
    end
  end

  // Fault record ring; the oldest entry is overwritten
  wire [QW-1:0] wp_nxt = (rec_wp == QW'(REC_DEPTH - 1)) ? '0 : rec_wp + 1'b1;
  wire [QW-1:0] ridx   = QW'(back(int'(rec_wp), int'(rsel), REC_DEPTH));
  wire [31:0]   inf_val = {3'b000, remain, ctrl[CTRL_GRP +: 3], ph_q,
                           ev_raw[EV_BL_ON], ev_raw[EV_TR_ON], ev_raw[EV_ST_ON]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_wp <= '0;
      for (int i = 0; i < REC_DEPTH; i++) begin
        rec_ts[i]  <= '0;
        rec_inf[i] <= '0;
        rec_cur[i] <= '0;
        rec_pf[i]  <= '0;
      end
    end else if (rec_trig) begin
      rec_ts[rec_wp]  <= stamp;
      rec_inf[rec_wp] <= inf_val;
      rec_cur[rec_wp] <= {h_now, h_pre};
      rec_pf[rec_wp]  <= pf_val;
      rec_wp          <= wp_nxt;
    end
  end

  // Ratio of highest current to pick-up, refreshed every cycle
  jl_ratio_div #(
    .NW (RW),
    .DW (16)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tick),
    .num     (RW'(cur_max) * RATIO_SCALE),
    .den     (pickup),
    .done    (div_done),
    .quo     (div_quo)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio <= '0;
    end else if (div_done) begin
      ratio <= div_quo;
    end
  end

  // APB decode; read data is taken in the setup cycle
  wire setup = psel && !penable;
  wire wr    = psel && penable && pwrite;
  wire rd_hit = paddr inside {OFF_CTRL, OFF_PICKUP, OFF_OPDLY, OFF_RLDLY,
                              OFF_STATUS, OFF_EXPECT, OFF_REMAIN, OFF_RATIO,
                              OFF_CNT_ST, OFF_CNT_TR, OFF_CNT_BL, OFF_STAMP,
                              OFF_REC_SEL, OFF_REC_TS, OFF_REC_INF,
                              OFF_REC_CUR, OFF_REC_PF};
  wire [31:0] status = {28'h000_0000, pick, blk_smp, state};

  assign rd_mux =
    (paddr == OFF_CTRL)    ? 32'(ctrl)            :
    (paddr == OFF_PICKUP)  ? 32'(pickup)          :
    (paddr == OFF_OPDLY)   ? 32'(opdly)           :
    (paddr == OFF_RLDLY)   ? 32'(rldly)           :
    (paddr == OFF_STATUS)  ? status               :
    (paddr == OFF_EXPECT)  ? 32'(opdly)           :
    (paddr == OFF_REMAIN)  ? 32'(remain)          :
    (paddr == OFF_RATIO)   ? 32'(ratio)           :
    (paddr == OFF_CNT_ST)  ? cnt_st               :
    (paddr == OFF_CNT_TR)  ? cnt_tr               :
    (paddr == OFF_CNT_BL)  ? cnt_bl               :
    (paddr == OFF_STAMP)   ? stamp                :
    (paddr == OFF_REC_SEL) ? 32'(rsel)            :
    (paddr == OFF_REC_TS)  ? rec_ts[ridx]         :
    (paddr == OFF_REC_INF) ? rec_inf[ridx]        :
    (paddr == OFF_REC_CUR) ? rec_cur[ridx]        :
    (paddr == OFF_REC_PF)  ? 32'(rec_pf[ridx])    : '0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

  // Read capture and settings writes; settings may change live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      err_q  <= 1'b0;
      ctrl   <= CTRL_RST;
      pickup <= PICKUP_RST;
      opdly  <= OPDLY_RST;
      rldly  <= RLDLY_RST;
      rsel   <= '0;
    end else begin
      if (setup) begin
        prdata <= rd_mux;
        err_q  <= !rd_hit;
      end
      if (wr && paddr == OFF_CTRL)    ctrl   <= pwdata[5:0];
      if (wr && paddr == OFF_PICKUP)  pickup <= pwdata[15:0];
      if (wr && paddr == OFF_OPDLY)   opdly  <= pwdata[TW-1:0];
      if (wr && paddr == OFF_RLDLY)   rldly  <= pwdata[TW-1:0];
      // Selector above eleven is clamped to the oldest record
      if (wr && paddr == OFF_REC_SEL) begin
        rsel <= (pwdata[QW-1:0] > QW'(REC_DEPTH - 1)) ? QW'(REC_DEPTH - 1) : pwdata[QW-1:0];
      end
    end
  end

  // Checks on the stage behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  trip_has_start_a: assert property (trip |-> start)
    else $error("trip without start");
  block_excl_a: assert property (blocked |-> !start && !trip)
    else $error("blocked together with start");
  start_entry_a: assert property (
    tick && state == JL_NORMAL && pick && !blk_s2 |=> start)
    else $error("start missed on pick-up");
  block_entry_a: assert property (
    tick && state == JL_NORMAL && pick && blk_s2 |=> blocked && !start)
    else $error("blocked missed on pick-up");
  block_clears_a: assert property (
    tick && state == JL_START && blk_s2 |=> !start && ev_raw[EV_ST_OFF])
    else $error("block did not clear start");
  state_tick_a: assert property (!tick |=> $stable(state))
    else $error("state moved between cycles");
  evt_mask_a: assert property (evt_valid |-> (evt_flags & ~$past(ev_sel)) == 6'h00)
    else $error("unselected edge stored");
  cnt_start_a: assert property (
    upd && ev_raw[EV_ST_ON] |=> cnt_st == $past(cnt_st) + 32'h0000_0001)
    else $error("start counter not advanced");
  ring_next_a: assert property (
    rec_trig |=> rec_wp == $past(wp_nxt) && rec_ts[$past(rec_wp)] == $past(stamp))
    else $error("fault record ring not advanced");
  remain_down_a: assert property (
    tick && state == JL_START && next_state == JL_START
    |=> remain == $past(remain) - 20'h0_0001)
    else $error("remaining time not counting down");
endmodule : jl_load_jam

/* tb/jl_phase_src.sv */
/*
  Far-side model: phase currents and the blocking pin.
  Assumes commands from the bench, changed just after pclk edges.
*/
`timescale 1ns/100ps
module jl_phase_src (
  // Clock and commands
  input  wire logic             pclk,
  input  wire logic [2:0][15:0] amp_cmd,
  input  wire logic             blk_cmd,
  // Levels toward the stage
  output logic [15:0]           i_l1,
  output logic [15:0]           i_l2,
  output logic [15:0]           i_l3,
  output logic                  block_in
);
  // Defined levels from time zero
  initial {i_l3, i_l2, i_l1, block_in} = '0;
  // Block is held for whole cycles, long before any delay ends
  always @(posedge pclk) begin
    {i_l3, i_l2, i_l1} <= amp_cmd;
    block_in           <= blk_cmd;
  end
endmodule : jl_phase_src

/* tb/jl_load_jam_test.sv */
/*
  Self-checking bench of the load jam stage over APB.
  Assumes a short program cycle of TK clocks.
*/
`timescale 1ns/100ps
module jl_load_jam_test;
  import jl_pkg::*;
  localparam int TK = 100; // Short cycle keeps the run brief
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, evt_stamp;
  logic pready, pslverr, e, start, trip, blocked, evt_valid, block_in, blk = 0;
  logic [5:0] evt_flags, ev_or = 0; // All flags seen since last clear
  logic [15:0] i_l1, i_l2, i_l3;
  logic [2:0][15:0] amp = 0;
  int n_mismatch = 0, tests_run = 0, seed = 21, cst = 0, ctr = 0, cbl = 0;
  always #25 pclk = ~pclk;
  // Collect every event pulse
  always @(posedge pclk) if (evt_valid === 1'b1) ev_or <= ev_or | evt_flags;
  jl_load_jam #(.TICK_CLKS(TK)) jl_load_jam_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .i_l1,
    .i_l2, .i_l3, .block_in, .start, .trip, .blocked, .evt_valid,
    .evt_flags, .evt_stamp);
  jl_phase_src jl_phase_src_inst (.pclk, .amp_cmd(amp), .blk_cmd(blk),
    .i_l1, .i_l2, .i_l3, .block_in);
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      n_mismatch++;
    end
  endtask : chk
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    if (k >= 20) begin
      n_mismatch++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(string nm, logic [7:0] a, logic [31:0] x, logic [31:0] m = '1);
    apb(0, a, 0);
    chk(nm, x, q & m);
  endtask : rd
  // Poll the condition field, bounded
  task automatic wait_st(logic [1:0] s);
    int k;
    for (k = 0; k < 300; k++) begin
      apb(0, OFF_STATUS, 0);
      if (q[1:0] === s) break;
    end
    if (k == 300) begin
      $display("[ERR] status expected %h seen %h", s, q[1:0]);
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_st
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd("ctrl", OFF_CTRL, {26'h0, CTRL_RST});
    rd("pickup", OFF_PICKUP, 32'h0000_0258);
    rd("opdly", OFF_OPDLY, {12'h0, OPDLY_RST});
    rd("status", OFF_STATUS, 32'h0000_0000);
    apb(0, 8'hF0, 0);
    chk("unmapped err", 1, e);
    $display("test reset done");
    // Loads at or below the setting, L1 on the boundary
    repeat (4) begin
      amp[0] <= 16'd600;
      for (int p = 1; p < 3; p++) amp[p] <= 16'($unsigned($random(seed)) % 601);
      repeat (2 * TK) @(posedge pclk);
      chk("start low", 0, start);
    end
    $display("test below pick-up done");
    // Start, then definite time trip after four cycles
    apb(1, OFF_OPDLY, 4);
    amp <= {16'd100, 16'd700, 16'd100};
    wait_st(2'b01);
    cst++;
    rd("expect", OFF_EXPECT, 4);
    repeat (TK / 2) @(posedge pclk);
    rd("ratio", OFF_RATIO, 700 * 100 / 600);
    apb(0, OFF_REMAIN, 0);
    chk("remain range", 1, q > 0 && q <= 4);
    wait_st(2'b11);
    ctr++;
    chk("start in trip", 1, start);
    apb(0, OFF_STAMP, 0);
    chk("stamp", 1, evt_stamp > 0 && evt_stamp <= q);
    rd("start count", OFF_CNT_ST, cst);
    rd("trip count", OFF_CNT_TR, ctr);
    rd("rec trip", OFF_REC_INF, 32'h12, 32'h1FF);
    apb(1, OFF_REC_SEL, 1);
    rd("rec start", OFF_REC_INF, 32'h11, 32'h1FF);
    rd("rec cur", OFF_REC_CUR, 32'h02BC_0000, 32'hFFFF_0000);
    $display("test trip done");
    // Block while tripped: release, then blocked condition
    blk <= 1;
    wait_st(2'b10);
    cbl++;
    rd("status bits", OFF_STATUS, 32'h0E, 32'hF);
    rd("block count", OFF_CNT_BL, cbl);
    chk("trip off", 0, trip);
    chk("events", 6'h1F, ev_or);
    $display("test block done");
    // Only on edges selected: off edges must vanish
    apb(1, OFF_CTRL, 3);
    ev_or <= 0;
    blk <= 0;
    amp <= '0;
    wait_st(2'b00);
    repeat (4) @(posedge pclk);
    chk("off masked", 0, ev_or);
    apb(1, OFF_REC_SEL, 15);
    rd("rec sel clamp", OFF_REC_SEL, 11);
    // Block arriving while started: start drops, then blocked
    apb(1, OFF_OPDLY, 40);
    amp <= {16'd100, 16'd100, 16'd900};
    wait_st(2'b01);
    blk <= 1;
    wait_st(2'b00);
    chk("start cleared", 0, start);
    wait_st(2'b10);
    rd("block count 2", OFF_CNT_BL, 2);
    blk <= 0;
    amp <= '0;
    wait_st(2'b00);
    $display("test selection done");
    wrap_up();
  end
endmodule : jl_load_jam_test
